// File: pkg/vpa_pkg.sv
// constants, field layout and state encoding of the emulated phy block
// assumes a 50 MHz system clock and a 32-bit avalon-mm register bus
package vpa_pkg;

	localparam int unsigned CLK_PERIOD_NS   = 20;
	localparam int unsigned EMU_RST_TIME_NS = 102000;
	localparam int unsigned EMU_RST_CYCLES  = EMU_RST_TIME_NS / CLK_PERIOD_NS;
	localparam int          RST_CNT_W       = 13;

	// byte addresses, one aligned word each
	localparam logic [7:0] OFS_BASIC_CTRL = 8'h00;
	localparam logic [7:0] OFS_BASIC_STAT = 8'h04;
	localparam logic [7:0] OFS_ID_HI      = 8'h08;
	localparam logic [7:0] OFS_ID_LO      = 8'h0C;
	localparam logic [7:0] OFS_ADVERT     = 8'h10;
	localparam logic [7:0] OFS_PARTNER    = 8'h14;
	localparam logic [7:0] OFS_EXPANSION  = 8'h18;
	localparam logic [7:0] OFS_CHIP_RST   = 8'h40;

	// basic control fields
	localparam int CTRL_RESET    = 15;
	localparam int CTRL_LOOPBACK = 14;
	localparam int CTRL_SPEED    = 13;
	localparam int CTRL_NEG_EN   = 12;
	localparam int CTRL_PDOWN    = 11;
	localparam int CTRL_ISOLATE  = 10;
	localparam int CTRL_RESTART  = 9;
	localparam int CTRL_DUPLEX   = 8;
	localparam int CTRL_COLTEST  = 7;

	// advertisement / partner fields; tech[3:0] = 100F,100H,10F,10H
	localparam int ADV_TECH_LSB  = 5;
	localparam int ADV_PAUSE_SYM = 10;
	localparam int ADV_PAUSE_ASY = 11;
	localparam int TECH_100F     = 3;
	localparam int TECH_100H     = 2;
	localparam int TECH_10F      = 1;
	localparam int TECH_10H      = 0;

	localparam int STAT_NEG_DONE = 5;
	localparam int EXP_LP_ABLE   = 0;
	localparam int EXP_PAGE_RX   = 1;
	localparam int CHIP_DIG_RST  = 0;
	localparam int CHIP_EMU_RST  = 1;

	// values after reset
	localparam logic       CTRL_NEG_EN_RST = 1'b1;
	localparam logic       CTRL_SPEED_RST  = 1'b1;
	localparam logic       CTRL_DUPLEX_RST = 1'b1;
	localparam logic [3:0] ADV_TECH_RST    = 4'hF;
	localparam logic       ADV_SYM_RST     = 1'b1;
	localparam logic       ADV_ASY_RST     = 1'b0;
	localparam logic [4:0] SELECTOR_8023   = 5'h01;
	localparam logic [15:0] STAT_FIXED     = 16'h780D;
	localparam logic [15:0] UNMAPPED_VAL   = 16'hFFFF;

	typedef enum logic [1:0] {
		NS_IDLE     = 2'b00,
		NS_COMPLETE = 2'b01,
		NS_PAGE     = 2'b10,
		NS_RESULT   = 2'b11
	} vpa_neg_state_t;

endpackage

// File: logic/vpa_neg_resolve.sv
// emulated partner abilities and highest common mode resolution
// purely combinational; the caller registers the result
`timescale 1ns/10ps
module vpa_neg_resolve
(
	input  wire logic [3:0] i_adv_tech,
	input  wire logic       i_duplex_pin,
	input  wire logic       i_duplex_pol,
	input  wire logic       i_speed_strap,
	output logic      [3:0] o_lp_tech,
	output logic            o_lp_able,
	output logic            o_res_100,
	output logic            o_res_full
);
	import vpa_pkg::*;

	logic       partner_full;
	logic [3:0] partner_tech;
	logic [3:0] common;

	always_comb
	begin
		// partner duplex: full when pin level matches polarity strap
		partner_full = (i_duplex_pin == i_duplex_pol);
		partner_tech = '0;
		partner_tech[TECH_10H]  = 1'b1;
		partner_tech[TECH_10F]  = partner_full;
		partner_tech[TECH_100H] = i_speed_strap;
		partner_tech[TECH_100F] = i_speed_strap & partner_full;
		common = i_adv_tech & partner_tech;
		o_lp_able  = |common;
		o_lp_tech  = partner_tech;
		o_res_100  = 1'b0;
		o_res_full = 1'b0;
		if (common[TECH_100F])
		begin
			o_res_100  = 1'b1;
			o_res_full = 1'b1;
		end
		else if (common[TECH_100H])
		begin
			o_res_100 = 1'b1;
		end
		else if (common[TECH_10F])
		begin
			o_res_full = 1'b1;
		end
		else if (!common[TECH_10H])
		begin
			// parallel detect: half duplex, strap speed, one tech bit
			o_res_100 = i_speed_strap;
			o_lp_tech = i_speed_strap ? 4'h4 : 4'h1;
		end
	end

endmodule

// File: logic/vpa_emu_phy.sv
// emulated single-port phy register bank with emulated negotiation
// assumes a synchronous avalon-mm master and static strap levels
`timescale 1ns/10ps

// Contract
// - presents clause 22 style phy registers so a stock driver works
// - bank holds speed, duplex, loopback, isolate, collision test, negotiation status
// - emulated negotiation runs only while the enable bit is set
// - negotiation restarts on resets, soft resets, restart bit, digital reset, reload
// - sequence: set complete, then page received, then store result
// - result comes from AND of local and partner ability bits
// - priority: 100 full, 100 half, 10 full, 10 half
// - no common bit falls back to emulated parallel detection
// - all four advertised ability bits set after reset, writable
// - advertisement writes do not alter result until renegotiation
// - partner abilities come from duplex pin, polarity and speed straps
// - no next page, remote fault or T4 support anywhere
// - pin and strap changes never rerun negotiation
// - common ability sets partner-able bit and loads partner abilities
// - host side is the local station, switch side the partner
// - fallback clears partner-able, half duplex, strap speed, one partner bit
// - negotiation disabled forces speed and duplex from control bits
// - partner pause bits mirror the local advertised pause bits
// - chip-level emulated reset bit self clears after about 102 us
module vpa_emu_phy
#(
	parameter int unsigned   RST_CYCLES = vpa_pkg::EMU_RST_CYCLES,
	parameter logic [15:0]   ID_HI      = 16'h0000, // arbitrary identity value
	parameter logic [15:0]   ID_LO      = 16'h0000  // arbitrary identity value
)
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	input  wire logic        i_port0_duplex_pin,
	input  wire logic        i_duplex_pol_strap,
	input  wire logic        i_speed_strap,
	input  wire logic        i_eeprom_reload,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	output logic             o_speed_100,
	output logic             o_full_duplex,
	output logic             o_pause_sym,
	output logic             o_pause_asym,
	output logic             o_neg_complete
);
	import vpa_pkg::*;

	typedef struct packed {
		logic                 loopback;
		logic                 speed_sel;
		logic                 neg_en;
		logic                 pdown;
		logic                 isolate;
		logic                 restart;
		logic                 duplex;
		logic                 coltest;
		logic [3:0]           adv_tech;
		logic                 adv_sym;
		logic                 adv_asy;
		logic [3:0]           lp_tech;
		logic                 lp_sym;
		logic                 lp_asy;
		logic                 neg_done;
		logic                 page_rx;
		logic                 lp_able;
		logic                 res_100;
		logic                 res_full;
		vpa_neg_state_t       st;
		logic                 rst_busy;
		logic [RST_CNT_W-1:0] rst_cnt;
		logic                 waitreq;
		logic [31:0]          rdata;
		logic                 out_100;
		logic                 out_full;
		logic                 out_sym;
		logic                 out_asy;
	} vpa_state_t;

	localparam logic [RST_CNT_W-1:0] RST_LAST = RST_CNT_W'(RST_CYCLES - 1);

	// power-on state enters the sequence at once
	localparam vpa_state_t ST_RST = '{
		speed_sel: CTRL_SPEED_RST, neg_en: CTRL_NEG_EN_RST, duplex: CTRL_DUPLEX_RST,
		adv_tech: ADV_TECH_RST, adv_sym: ADV_SYM_RST, adv_asy: ADV_ASY_RST,
		st: NS_COMPLETE, waitreq: 1'b1, default: '0};

	vpa_state_t s_q;
	vpa_state_t s_d;
	logic [3:0] nr_lp_tech;
	logic       nr_lp_able;
	logic       nr_res_100;
	logic       nr_res_full;

	vpa_neg_resolve u_resolve
	(
		.i_adv_tech    (s_q.adv_tech),
		.i_duplex_pin  (i_port0_duplex_pin),
		.i_duplex_pol  (i_duplex_pol_strap),
		.i_speed_strap (i_speed_strap),
		.o_lp_tech     (nr_lp_tech),
		.o_lp_able     (nr_lp_able),
		.o_res_100     (nr_res_100),
		.o_res_full    (nr_res_full)
	);

	// register view; local = host side, partner = switch side
	function automatic logic [15:0] reg_view(input vpa_state_t s, input logic [7:0] a);
		logic [15:0] v;
		v = UNMAPPED_VAL;
		case (a)
			OFS_BASIC_CTRL: v = {1'b0, s.loopback, s.speed_sel, s.neg_en, s.pdown,
				s.isolate, s.restart, s.duplex, s.coltest, 7'h00};
			OFS_BASIC_STAT: v = STAT_FIXED | (16'(s.neg_done) << STAT_NEG_DONE);
			OFS_ID_HI:      v = ID_HI;
			OFS_ID_LO:      v = ID_LO;
			// np, remote fault and t4 bits stay zero
			OFS_ADVERT:     v = {4'h0, s.adv_asy, s.adv_sym, 1'b0, s.adv_tech,
				SELECTOR_8023};
			OFS_PARTNER:    v = {4'h0, s.lp_asy, s.lp_sym, 1'b0, s.lp_tech,
				SELECTOR_8023};
			OFS_EXPANSION:  v = {14'h0000, s.page_rx, s.lp_able};
			OFS_CHIP_RST:   v = {14'h0000, s.rst_busy, 1'b0};
			default:        v = UNMAPPED_VAL;
		endcase
		return v;
	endfunction

	function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] be);
		return {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
	endfunction

	// register fields back to power-on values, bus and reset timer untouched
	function automatic vpa_state_t soft_defaults(input vpa_state_t s);
		vpa_state_t r;
		r          = ST_RST;
		r.rst_busy = s.rst_busy;
		r.rst_cnt  = s.rst_cnt;
		r.waitreq  = s.waitreq;
		r.rdata    = s.rdata;
		r.st       = NS_IDLE;
		return r;
	endfunction

	logic        acc_go;
	logic        wr_go;
	logic [15:0] wv;
	logic        trig;
	logic        restore;

	always_comb
	begin
		s_d     = s_q;
		wv      = lane_merge(reg_view(s_q, i_address), i_writedata[15:0], i_byteenable[1:0]);
		acc_go  = (i_read | i_write) & s_q.waitreq;
		wr_go   = i_write & ~s_q.waitreq;
		trig    = 1'b0;
		restore = 1'b0;

		// one wait cycle, then answer; read data framed while waiting
		s_d.waitreq = ~acc_go;
		if (acc_go)
		begin
			s_d.rdata = {16'h0000, reg_view(s_q, i_address)};
		end

		if (wr_go)
		begin
			case (i_address)
				OFS_BASIC_CTRL:
				begin
					s_d.loopback  = wv[CTRL_LOOPBACK];
					s_d.speed_sel = wv[CTRL_SPEED];
					s_d.neg_en    = wv[CTRL_NEG_EN];
					s_d.pdown     = wv[CTRL_PDOWN];
					s_d.isolate   = wv[CTRL_ISOLATE];
					s_d.duplex    = wv[CTRL_DUPLEX];
					s_d.coltest   = wv[CTRL_COLTEST];
					if (wv[CTRL_RESTART])
					begin
						s_d.restart = 1'b1;
						trig        = 1'b1;
					end
					if (wv[CTRL_RESET])
					begin
						restore = 1'b1;
					end
				end
				OFS_ADVERT:
				begin
					// only the stored advertisement moves here
					s_d.adv_tech = wv[ADV_TECH_LSB +: 4];
					s_d.adv_sym  = wv[ADV_PAUSE_SYM];
					s_d.adv_asy  = wv[ADV_PAUSE_ASY];
				end
				OFS_CHIP_RST:
				begin
					if (wv[CHIP_DIG_RST] || wv[CHIP_EMU_RST])
					begin
						restore = 1'b1;
					end
					if (wv[CHIP_EMU_RST] && !s_q.rst_busy)
					begin
						s_d.rst_busy = 1'b1;
						s_d.rst_cnt  = '0;
					end
				end
				default:
				begin
					s_d.rst_cnt = s_d.rst_cnt;
				end
			endcase
		end

		// reload behaves like a block reset; strap moves are not events
		if (i_eeprom_reload)
		begin
			restore = 1'b1;
		end
		if (restore)
		begin
			s_d  = soft_defaults(s_d);
			trig = 1'b1;
		end

		// chip-level reset holds the bank at defaults while counting
		if (s_q.rst_busy)
		begin
			s_d = soft_defaults(s_d);
			if (s_q.rst_cnt == RST_LAST)
			begin
				s_d.rst_busy = 1'b0;
				trig         = 1'b1;
			end
			else
			begin
				s_d.rst_cnt = s_q.rst_cnt + 1'b1;
			end
		end

		case (s_q.st)
			NS_IDLE:
			begin
				s_d.st = NS_IDLE;
			end
			NS_COMPLETE:
			begin
				s_d.neg_done = 1'b1;
				s_d.restart  = 1'b0;
				s_d.st       = NS_PAGE;
			end
			NS_PAGE:
			begin
				s_d.page_rx = 1'b1;
				s_d.st      = NS_RESULT;
			end
			NS_RESULT:
			begin
				s_d.res_100  = nr_res_100;
				s_d.res_full = nr_res_full;
				s_d.lp_able  = nr_lp_able;
				s_d.lp_tech  = nr_lp_tech;
				s_d.lp_sym   = s_q.adv_sym;
				s_d.lp_asy   = s_q.adv_asy;
				s_d.st       = NS_IDLE;
			end
			default:
			begin
				s_d.st = NS_IDLE;
			end
		endcase

		if (trig && !s_d.rst_busy)
		begin
			s_d.neg_done = 1'b0;
			s_d.page_rx  = 1'b0;
			s_d.lp_able  = 1'b0;
			s_d.st       = NS_COMPLETE;
		end
		// disabling negotiation stops a sequence in flight
		if (!s_d.neg_en || s_d.rst_busy)
		begin
			s_d.st      = NS_IDLE;
			s_d.restart = 1'b0;
		end

		s_d.out_100  = s_q.neg_en ? s_q.res_100 : s_q.speed_sel;
		s_d.out_full = s_q.neg_en ? s_q.res_full : s_q.duplex;
		// pause comes from the stored result, so advert writes wait for renegotiation
		s_d.out_sym  = s_q.neg_en & s_q.res_full & s_q.lp_sym;
		s_d.out_asy  = s_q.neg_en & s_q.res_full & s_q.lp_asy;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s_q <= ST_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign o_readdata     = s_q.rdata;
	assign o_waitrequest  = s_q.waitreq;
	assign o_speed_100    = s_q.out_100;
	assign o_full_duplex  = s_q.out_full;
	assign o_pause_sym    = s_q.out_sym;
	assign o_pause_asym   = s_q.out_asy;
	assign o_neg_complete = s_q.neg_done;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	chk_bus_one_wait: assert property (
		(i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
		else $error("bus answer not after exactly one wait cycle");

	chk_seq_order: assert property (
		s_q.st == NS_COMPLETE && s_d.st == NS_PAGE
		|=> s_q.neg_done && !s_q.page_rx ##1 (s_q.page_rx || s_q.st != NS_RESULT))
		else $error("negotiation steps out of order");

	chk_page_needs_done: assert property (
		s_q.page_rx |-> s_q.neg_done)
		else $error("page received without negotiation complete");

	chk_neg_gated: assert property (
		!s_q.neg_en |-> s_q.st == NS_IDLE)
		else $error("negotiation ran while disabled");

	chk_fallback_half: assert property (
		s_q.st == NS_RESULT && !nr_lp_able && !trig && !restore && !s_q.rst_busy
		|=> !s_q.lp_able && !s_q.res_full && s_q.res_100 == $past(i_speed_strap)
		&& $onehot(s_q.lp_tech))
		else $error("parallel detect fallback wrong");

	chk_top_priority: assert property (
		s_q.st == NS_RESULT && nr_lp_able && s_q.adv_tech[TECH_100F] && nr_lp_tech[TECH_100F]
		&& !trig && !restore && !s_q.rst_busy |=> s_q.res_100 && s_q.res_full)
		else $error("100 full not chosen when common");

	chk_result_held: assert property (
		s_q.st == NS_IDLE && s_d.st == NS_IDLE && !restore && !s_q.rst_busy
		|=> $stable(s_q.res_100) && $stable(s_q.res_full))
		else $error("result changed without renegotiation");

	chk_forced_mode: assert property (
		!s_q.neg_en |=> o_speed_100 == $past(s_q.speed_sel) && o_full_duplex == $past(s_q.duplex))
		else $error("forced speed or duplex not applied");

	chk_restart_clear: assert property (
		s_q.restart |=> !s_q.restart)
		else $error("restart bit did not self clear");

	chk_partner_pause: assert property (
		s_q.st == NS_RESULT && !trig && !restore && !s_q.rst_busy
		|=> s_q.lp_sym == $past(s_q.adv_sym) && s_q.lp_asy == $past(s_q.adv_asy))
		else $error("partner pause does not mirror advertisement");

	chk_rst_timer: assert property (
		s_q.rst_busy |-> s_q.rst_cnt <= RST_LAST)
		else $error("emulated reset timer overran");

	cov_fallback: cover property (s_q.st == NS_RESULT && !nr_lp_able);
	cov_full_100: cover property (s_q.st == NS_RESULT && nr_res_100 && nr_res_full);
	cov_chip_rst: cover property (s_q.rst_busy ##1 !s_q.rst_busy);
	cov_restart:  cover property (s_q.restart ##1 s_q.st == NS_COMPLETE);

endmodule

// File: sim/vpa_mgmt_master.sv
// avalon-mm management master standing in for the external mac
// assumes one caller at a time; the bench watchdog bounds every wait
`timescale 1ns/10ps
module vpa_mgmt_master
(
	input  wire logic        i_mclk,
	input  wire logic        i_waitrequest,
	input  wire logic [31:0] i_readdata,
	output logic      [7:0]  o_address,
	output logic             o_read,
	output logic             o_write,
	output logic      [31:0] o_writedata,
	output logic      [3:0]  o_byteenable
);
	initial
	begin
		o_address = 8'hFF;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'hFFFFFFFF;
		o_byteenable = 4'h0;
	end

	// released address and data lines show the inverse so stale values never pass for a request
	task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge i_mclk);
		o_address <= a;
		o_writedata <= {16'h0000, d};
		o_byteenable <= 4'h3;
		o_read <= !wr;
		o_write <= wr;
		// no cycle count assumed; only the bench watchdog ends a hung wait
		do
		begin
			@(posedge i_mclk);
		end
		while (i_waitrequest !== 1'b0);
		q = i_readdata[15:0];
		o_read <= 1'b0;
		o_write <= 1'b0;
		o_address <= ~a;
		o_writedata <= ~{16'h0000, d};
		o_byteenable <= 4'h0;
	endtask
endmodule

// File: sim/virtual_phy_autoneg_emulation_tb.sv
// self-checking bench for the emulated phy bank and its negotiation
// assumes vpa_mgmt_master as bus partner and a shortened emulated reset
`timescale 1ns/10ps
`define CMP(g, e) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("unexpected at %0t: got %0h exp %0h", $time, g, e); \
		end \
	end
module virtual_phy_autoneg_emulation_tb;
	import vpa_pkg::*;
	localparam int unsigned RSTC = 20;
	logic        mclk;
	logic        rst;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic        dpin;
	logic        dpol;
	logic        spd;
	logic        reload;
	logic [31:0] rdata;
	logic        wait_rq;
	logic        speed_100;
	logic        full_duplex;
	logic        pause_sym;
	logic        pause_asym;
	logic        neg_complete;
	logic [15:0] adv;
	logic [15:0] q;
	logic [3:0]  e_lp;
	logic        e_able;
	logic        e_spd;
	logic        e_full;
	logic        e_sym;
	logic        e_asy;
	logic [15:0] fw;
	int          bad_count = 0;
	int          n_compared = 0;

	vpa_emu_phy #(.RST_CYCLES(RSTC)) dut (.i_mclk(mclk), .i_rst(rst), .i_address(address),
		.i_read(read), .i_write(write), .i_writedata(wdata), .i_byteenable(be),
		.i_port0_duplex_pin(dpin), .i_duplex_pol_strap(dpol), .i_speed_strap(spd),
		.i_eeprom_reload(reload), .o_readdata(rdata), .o_waitrequest(wait_rq),
		.o_speed_100(speed_100), .o_full_duplex(full_duplex), .o_pause_sym(pause_sym),
		.o_pause_asym(pause_asym), .o_neg_complete(neg_complete));

	vpa_mgmt_master mst (.i_mclk(mclk), .i_waitrequest(wait_rq), .i_readdata(rdata),
		.o_address(address), .o_read(read), .o_write(write), .o_writedata(wdata),
		.o_byteenable(be));

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		mst.access(1'b0, a, 16'h0000, d);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] x;
		mst.access(1'b1, a, d, x);
	endtask

	// straps are sampled here, at the trigger, since the device treats them as static
	task automatic predict();
		logic [3:0] c;
		logic       f;
		f = (dpin == dpol);
		e_sym = adv[10];
		e_asy = adv[11];
		e_lp = {spd & f, spd, f, 1'b1};
		c = adv[8:5] & e_lp;
		e_able = (c != 4'h0);
		if (c[3])
			{e_spd, e_full} = 2'b11;
		else if (c[2])
			{e_spd, e_full} = 2'b10;
		else if (c[1])
			{e_spd, e_full} = 2'b01;
		else if (c[0])
			{e_spd, e_full} = 2'b00;
		else
		begin
			{e_spd, e_full} = {spd, 1'b0};
			e_lp = {1'b0, spd, 1'b0, !spd};
		end
	endtask

	task automatic check_out();
		`CMP(speed_100, e_spd)
		`CMP(full_duplex, e_full)
		`CMP(pause_sym, e_full & e_sym)
		`CMP(pause_asym, e_full & e_asy)
		`CMP(neg_complete, 1'b1)
	endtask

	task automatic check_regs();
		rd(OFS_PARTNER, q);
		`CMP(q[11:5], {e_asy, e_sym, 1'b0, e_lp})
		`CMP(q[15:13], 3'b000)
		rd(OFS_EXPANSION, q);
		`CMP(q[1:0], {1'b1, e_able})
		rd(OFS_BASIC_STAT, q);
		`CMP(q, STAT_FIXED | 16'h0020)
	endtask

	task automatic negotiate();
		wr(OFS_BASIC_CTRL, 16'h3300);
		predict();
		repeat (8) @(posedge mclk);
		check_out();
		check_regs();
		rd(OFS_BASIC_CTRL, q);
		`CMP(q[9], 1'b0)
	endtask

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		final_report();
	end

	initial
	begin
		void'($urandom(65319));
		rst = 1'b1;
		{dpin, dpol, spd, reload} = 4'b1110;
		adv = 16'h05E1;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
		predict();
		check_out();
		check_regs();
		rd(OFS_BASIC_CTRL, q);
		`CMP(q, 16'h3100)
		rd(OFS_ADVERT, q);
		`CMP(q, 16'h05E1)
		wr(OFS_BASIC_STAT, 16'h0000);
		rd(OFS_BASIC_STAT, q);
		`CMP(q, STAT_FIXED | 16'h0020)
		wr(8'h20, 16'h0000);
		rd(8'h20, q);
		`CMP(q, 16'hFFFF)
		repeat (40)
		begin
			@(posedge mclk);
			{dpin, dpol, spd} <= 3'($urandom);
			repeat (8) @(posedge mclk);
			check_out();
			adv = {4'h0, 2'($urandom), 1'b0, 4'($urandom), 5'h01};
			wr(OFS_ADVERT, adv);
			repeat (8) @(posedge mclk);
			check_out();
			rd(OFS_ADVERT, q);
			`CMP(q, adv)
			negotiate();
		end
		// forced mode: every speed and duplex combination, storage bits toggled too
		for (int k = 0; k < 4; k++)
		begin
			fw = {1'b0, 1'(k), 1'(k >> 1), 1'b0, 1'(k), 1'(k >> 1), 1'b0, 1'(k),
				1'(k >> 1), 7'h00};
			wr(OFS_BASIC_CTRL, fw);
			repeat (8) @(posedge mclk);
			`CMP(speed_100, 1'(k >> 1))
			`CMP(full_duplex, 1'(k))
			`CMP(pause_sym, 1'b0)
			rd(OFS_BASIC_CTRL, q);
			`CMP(q, fw)
		end
		@(posedge mclk);
		{dpin, dpol, spd} <= 3'b111;
		for (int t = 0; t < 5; t++)
		begin
			adv = 16'h0021;
			wr(OFS_ADVERT, adv);
			negotiate();
			case (t)
				0: wr(OFS_BASIC_CTRL, 16'h8000);
				1: wr(OFS_CHIP_RST, 16'h0001);
				2:
				begin
					wr(OFS_CHIP_RST, 16'h0002);
					rd(OFS_CHIP_RST, q);
					`CMP(q[1], 1'b1)
					repeat (RSTC) @(posedge mclk);
				end
				3:
				begin
					rst <= 1'b1;
					@(posedge mclk);
					rst <= 1'b0;
				end
				default:
				begin
					reload <= 1'b1;
					@(posedge mclk);
					reload <= 1'b0;
				end
			endcase
			adv = 16'h05E1;
			predict();
			repeat (8) @(posedge mclk);
			check_out();
			rd(OFS_ADVERT, q);
			`CMP(q, 16'h05E1)
			rd(OFS_BASIC_CTRL, q);
			`CMP(q, 16'h3100)
		end
		rd(OFS_CHIP_RST, q);
		`CMP(q[1], 1'b0)
		final_report();
	end
endmodule
